// ==== include/dspc_pkg.sv ====
// Shared constants and types for the deep-sleep power configuration block
package dspc_pkg;
  // Register byte addresses
  localparam logic [31:0] DSPC_DS_ADDR = 32'h4004_8230;
  localparam logic [31:0] DSPC_WAKE_ADDR = 32'h4004_8234;
  localparam logic [31:0] DSPC_STAT_ADDR = 32'h4004_8240;
  // Reset values
  localparam logic [15:0] DSPC_DS_RST = 16'hFFFF;
  localparam logic [15:0] DSPC_WAKE_RST = 16'h88F0;
  localparam logic [15:0] DSPC_PD_RST = 16'h80F0;
  // Writable bits of the wake-up register; others keep reset value
  localparam logic [15:0] DSPC_WAKE_WMASK = 16'h80FF;
  // Power-down controls that exist as analog blocks
  localparam logic [15:0] DSPC_PD_USED = 16'h80FF;
  // Blocks forced down in deep sleep (all but brown-out and wdt osc)
  localparam logic [15:0] DSPC_SLEEP_FORCED = 16'h80B7;
  // Permitted deep-sleep register values
  localparam logic [15:0] DSPC_DS_BOTH_ON = 16'hFFB7;
  localparam logic [15:0] DSPC_DS_BOD_OFF = 16'hFFBF;
  localparam logic [15:0] DSPC_DS_WDT_OFF = 16'hFFF7;
  localparam logic [15:0] DSPC_DS_ALL_OFF = 16'hFFFF;
  // Power-down bit positions
  localparam int DSPC_RCOUT_BIT = 0;
  localparam int DSPC_RC_BIT = 1;
  localparam int DSPC_FLASH_BIT = 2;
  localparam int DSPC_BOD_BIT = 3;
  localparam int DSPC_CONV_BIT = 4;
  localparam int DSPC_MOSC_BIT = 5;
  localparam int DSPC_WDTOSC_BIT = 6;
  localparam int DSPC_PLL_BIT = 7;
  localparam int DSPC_COMP_BIT = 15;
  // Status register bit positions
  localparam int DSPC_ST_SLEEP = 0;
  localparam int DSPC_ST_LOCK = 1;
  localparam int DSPC_ST_SRC_OSC = 2;
  localparam int DSPC_ST_SRC_RC = 3;
  localparam int DSPC_ST_DS_LEGAL = 4;
  localparam int DSPC_ST_BLOCKED = 5;
  // AXI response codes
  localparam logic [1:0] DSPC_RESP_OKAY = 2'b00;
  localparam logic [1:0] DSPC_RESP_SLVERR = 2'b10;
  typedef enum logic {DSPC_RUN, DSPC_SLEEP} dspc_state_t;
endpackage : dspc_pkg

// ==== include/dspc_reg_if.sv ====
// Register access carrier between the bus slave and the register file
`timescale 1ns/10ps
interface dspc_reg_if;
  logic wr_en;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
               input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface : dspc_reg_if

// ==== logic/dspc_axi_slave.sv ====
// AXI4-Lite slave that turns bus transfers into register accesses
`timescale 1ns/10ps
module dspc_axi_slave import dspc_pkg::*; (
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] awaddr, // Write address
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  output logic [1:0] bresp, // Write response
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  input wire logic [31:0] araddr, // Read address
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  dspc_reg_if.bus rif // Register side
);
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [31:0] aw_addr_reg, aw_addr_next, w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_next, rvalid_next, awready_next, wready_next, arready_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] rdata_next;
  logic fire;

  assign fire = aw_hold_reg && w_hold_reg && !bvalid;
  assign rif.wr_en = fire;
  assign rif.wr_addr = aw_addr_reg;
  assign rif.wr_data = w_data_reg;
  assign rif.wr_strb = w_strb_reg;
  assign rif.rd_en = arvalid && arready;
  assign rif.rd_addr = araddr;

  always_comb begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid;
    bresp_next = bresp;
    rvalid_next = rvalid;
    rresp_next = rresp;
    rdata_next = rdata;
    // Address and data may arrive in either order
    if (awvalid && awready) begin
      aw_hold_next = 1'b1;
      aw_addr_next = awaddr;
    end
    if (wvalid && wready) begin
      w_hold_next = 1'b1;
      w_data_next = wdata;
      w_strb_next = wstrb;
    end
    if (fire) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = rif.wr_ok ? DSPC_RESP_OKAY : DSPC_RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid_next = 1'b0;
    end
    if (rif.rd_en) begin
      rvalid_next = 1'b1;
      rdata_next = rif.rd_ok ? rif.rd_data : 32'h0000_0000;
      rresp_next = rif.rd_ok ? DSPC_RESP_OKAY : DSPC_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid_next = 1'b0;
    end
    // One transfer of each kind at a time
    awready_next = !aw_hold_next && !bvalid_next;
    wready_next = !w_hold_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 32'h0000_0000;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= DSPC_RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= DSPC_RESP_OKAY;
      rdata <= 32'h0000_0000;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid <= bvalid_next;
      bresp <= bresp_next;
      rvalid <= rvalid_next;
      rresp <= rresp_next;
      rdata <= rdata_next;
      awready <= awready_next;
      wready <= wready_next;
      arready <= arready_next;
    end
  end
endmodule : dspc_axi_slave

// ==== logic/dspc_lock_guard.sv ====
// Keeps watchdog-protected bits unchanged while the clock lock is set
`timescale 1ns/10ps
module dspc_lock_guard import dspc_pkg::*; (
  input wire logic lock, // Watchdog clock lock
  input wire logic src_osc, // Watchdog clocked by wdt oscillator
  input wire logic src_rc, // Watchdog clocked by internal RC osc
  input wire logic [15:0] ds_old, // Current deep-sleep value
  input wire logic [15:0] ds_new, // Proposed deep-sleep value
  input wire logic [15:0] wake_old, // Current wake-up value
  input wire logic [15:0] wake_new, // Proposed wake-up value
  output logic [15:0] ds_out, // Guarded deep-sleep value
  output logic [15:0] wake_out // Guarded wake-up value
);
  logic [15:0] ds_keep, wake_keep;

  always_comb begin
    ds_keep = 16'h0000;
    wake_keep = 16'h0000;
    ds_keep[DSPC_WDTOSC_BIT] = lock && src_osc;
    wake_keep[DSPC_WDTOSC_BIT] = lock && src_osc;
    wake_keep[DSPC_RCOUT_BIT] = lock && src_rc;
    wake_keep[DSPC_RC_BIT] = lock && src_rc;
    ds_out = (ds_old & ds_keep) | (ds_new & ~ds_keep);
    wake_out = (wake_old & wake_keep) | (wake_new & ~wake_keep);
  end
endmodule : dspc_lock_guard

// ==== logic/dspc_top.sv ====
// Deep-sleep and wake-up power configuration registers with sleep sequencing
// Function
// - Deep-sleep bit 6 writes ignored while locked on wdt osc clock.
// - Wake-up bit 6 writes ignored while locked on wdt osc clock.
// - Wake-up bits 0 and 1 ignored while locked on RC clock.
// - Deep-sleep bit 3 powers brown-out detector in sleep; resets to 1.
// - Deep-sleep bit 6 powers wdt oscillator in sleep; resets to 1.
// - Wake-up register picks blocks powered on leaving deep sleep.
// - Wake-up bits 0 to 3 control RC out, RC, flash, brown-out; reset 0.
// - Wake-up bits 4-7 and 15 control other blocks; reset 1.
// - Deep sleep shuts all blocks but brown-out and wdt oscillator.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module dspc_top import dspc_pkg::*; (
  input wire logic clk, // System clock, 20 MHz
  input wire logic reset_n, // Synchronous reset
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] awaddr, // Write address
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  output logic [1:0] bresp, // Write response
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  input wire logic [31:0] araddr, // Read address
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  input wire logic wdt_clock_lock, // Watchdog mode bit 5
  input wire logic wdt_src_osc, // Watchdog clocked by wdt oscillator
  input wire logic wdt_src_rc, // Watchdog clocked by internal RC osc
  input wire logic sleep_enter, // Pulse: enter deep sleep
  input wire logic sleep_exit, // Pulse: leave deep sleep
  output logic [15:0] analog_pd, // Active power-down controls
  output logic in_deep_sleep // High while in deep sleep
);
  dspc_reg_if rif();

  dspc_state_t state_reg, state_next;
  logic [15:0] ds_reg, ds_next, wake_reg, wake_next;
  logic [15:0] pd_next;
  logic sleep_next;
  logic blocked_reg, blocked_next;
  logic ds_hit, wake_hit, stat_hit;
  logic [15:0] wr_merge, ds_cand, wake_cand, ds_guard, wake_guard;
  logic ds_legal, guard_active_ds, guard_active_wake;
  logic [15:0] sleep_pd;
  logic [31:0] status_word;

  dspc_axi_slave u_axi (
    .clk(clk),
    .reset_n(reset_n),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .rif(rif.bus)
  );

  dspc_lock_guard u_guard (
    .lock(wdt_clock_lock),
    .src_osc(wdt_src_osc),
    .src_rc(wdt_src_rc),
    .ds_old(ds_reg),
    .ds_new(ds_cand),
    .wake_old(wake_reg),
    .wake_new(wake_cand),
    .ds_out(ds_guard),
    .wake_out(wake_guard)
  );

  assign ds_hit = rif.wr_addr == DSPC_DS_ADDR;
  assign wake_hit = rif.wr_addr == DSPC_WAKE_ADDR;
  assign stat_hit = rif.wr_addr == DSPC_STAT_ADDR;
  assign rif.wr_ok = ds_hit || wake_hit || stat_hit;

  // Legal deep-sleep value depends on the lock state
  assign ds_legal = wdt_clock_lock ?
      (ds_reg == DSPC_DS_BOTH_ON || ds_reg == DSPC_DS_BOD_OFF) :
      (ds_reg == DSPC_DS_BOTH_ON || ds_reg == DSPC_DS_BOD_OFF ||
       ds_reg == DSPC_DS_WDT_OFF || ds_reg == DSPC_DS_ALL_OFF);
  assign guard_active_ds = wdt_clock_lock && wdt_src_osc;
  assign guard_active_wake = wdt_clock_lock && (wdt_src_osc || wdt_src_rc);

  // Byte lanes above bit 15 hold no storage
  always_comb begin
    wr_merge = ds_hit ? ds_reg : wake_reg;
    if (rif.wr_strb[0]) begin
      wr_merge[7:0] = rif.wr_data[7:0];
    end
    if (rif.wr_strb[1]) begin
      wr_merge[15:8] = rif.wr_data[15:8];
    end
    ds_cand = wr_merge;
    wake_cand = (wr_merge & DSPC_WAKE_WMASK) | (wake_reg & ~DSPC_WAKE_WMASK);
  end

  always_comb begin
    ds_next = ds_reg;
    wake_next = wake_reg;
    blocked_next = blocked_reg;
    if (rif.wr_en && ds_hit) begin
      ds_next = ds_guard;
    end
    if (rif.wr_en && wake_hit) begin
      wake_next = wake_guard;
    end
    if (rif.wr_en && stat_hit && rif.wr_data[DSPC_ST_BLOCKED]) begin
      blocked_next = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (rif.wr_en && ((ds_hit && guard_active_ds) ||
        (wake_hit && guard_active_wake))) begin
      blocked_next = 1'b1;
    end
  end

  // Sleep image: every block down except the two kept by configuration
  always_comb begin
    sleep_pd = DSPC_SLEEP_FORCED;
    sleep_pd[DSPC_BOD_BIT] = ds_reg[DSPC_BOD_BIT];
    sleep_pd[DSPC_WDTOSC_BIT] = ds_reg[DSPC_WDTOSC_BIT];
  end

  always_comb begin
    state_next = state_reg;
    pd_next = analog_pd;
    unique case (state_reg)
      DSPC_RUN: begin
        if (sleep_enter) begin
          state_next = DSPC_SLEEP;
          pd_next = sleep_pd;
        end
      end
      DSPC_SLEEP: begin
        if (sleep_exit) begin
          state_next = DSPC_RUN;
          pd_next = wake_reg & DSPC_PD_USED;
        end
      end
    endcase
    sleep_next = state_next == DSPC_SLEEP;
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[DSPC_ST_SLEEP] = in_deep_sleep;
    status_word[DSPC_ST_LOCK] = wdt_clock_lock;
    status_word[DSPC_ST_SRC_OSC] = wdt_src_osc;
    status_word[DSPC_ST_SRC_RC] = wdt_src_rc;
    status_word[DSPC_ST_DS_LEGAL] = ds_legal;
    status_word[DSPC_ST_BLOCKED] = blocked_reg;
  end

  always_comb begin
    rif.rd_ok = 1'b1;
    unique case (rif.rd_addr)
      DSPC_DS_ADDR: rif.rd_data = {16'h0000, ds_reg};
      DSPC_WAKE_ADDR: rif.rd_data = {16'h0000, wake_reg};
      DSPC_STAT_ADDR: rif.rd_data = status_word;
      default: begin
        rif.rd_data = 32'h0000_0000;
        rif.rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ds_reg <= DSPC_DS_RST;
      wake_reg <= DSPC_WAKE_RST;
      blocked_reg <= 1'b0;
      state_reg <= DSPC_RUN;
      analog_pd <= DSPC_PD_RST;
      in_deep_sleep <= 1'b0;
    end else begin
      ds_reg <= ds_next;
      wake_reg <= wake_next;
      blocked_reg <= blocked_next;
      state_reg <= state_next;
      analog_pd <= pd_next;
      in_deep_sleep <= sleep_next;
    end
  end

  ds_osc_lock_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rif.wr_en && ds_hit && wdt_clock_lock && wdt_src_osc)
      |=> ds_reg[DSPC_WDTOSC_BIT] == $past(ds_reg[DSPC_WDTOSC_BIT]))
    else $error("deep-sleep wdt osc bit changed while locked");

  wake_osc_lock_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rif.wr_en && wake_hit && wdt_clock_lock && wdt_src_osc)
      |=> $stable(wake_reg[DSPC_WDTOSC_BIT]))
    else $error("wake-up wdt osc bit changed while locked");

  wake_rc_lock_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rif.wr_en && wake_hit && wdt_clock_lock && wdt_src_rc)
      |=> wake_reg[1:0] == $past(wake_reg[1:0]))
    else $error("wake-up RC bits changed while locked");

  sleep_bod_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_reg == DSPC_RUN && sleep_enter)
      |=> in_deep_sleep && analog_pd[DSPC_BOD_BIT] ==
          $past(ds_reg[DSPC_BOD_BIT]))
    else $error("brown-out control not taken from deep-sleep register");

  sleep_wdt_osc_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_reg == DSPC_RUN && sleep_enter)
      |=> analog_pd[DSPC_WDTOSC_BIT] == $past(ds_reg[DSPC_WDTOSC_BIT]))
    else $error("wdt osc control not taken from deep-sleep register");

  sleep_forced_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    in_deep_sleep |-> (analog_pd & DSPC_SLEEP_FORCED) == DSPC_SLEEP_FORCED)
    else $error("analog block left powered in deep sleep");

  wake_apply_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_reg == DSPC_SLEEP && sleep_exit)
      |=> !in_deep_sleep && analog_pd == ($past(wake_reg) & DSPC_PD_USED))
    else $error("wake-up configuration not applied on exit");

  wake_low_rst_a: assert property (
    @(posedge clk)
    !reset_n |=> wake_reg[3:0] == 4'h0 && ds_reg == DSPC_DS_RST)
    else $error("wake-up low bits or deep-sleep reset value wrong");

  wake_high_rst_a: assert property (
    @(posedge clk)
    !reset_n |=> wake_reg[7:4] == 4'hF && wake_reg[DSPC_COMP_BIT])
    else $error("wake-up high bits reset value wrong");

  blocked_set_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rif.wr_en && ds_hit && guard_active_ds) |=> blocked_reg)
    else $error("blocked-write flag not set");

  wake_blocked_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rif.wr_en && wake_hit && guard_active_wake) |=> blocked_reg)
    else $error("blocked-write flag not set by wake-up write");

  blocked_clear_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rif.wr_en && stat_hit && rif.wr_data[DSPC_ST_BLOCKED])
      |=> !blocked_reg)
    else $error("blocked-write flag not cleared");

  sleep_hold_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_reg == DSPC_SLEEP && !sleep_exit) |=> $stable(analog_pd))
    else $error("power-down controls moved during deep sleep");

  run_hold_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_reg == DSPC_RUN && !sleep_enter) |=> $stable(analog_pd))
    else $error("power-down controls moved while running");

  ds_bod_write_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rif.wr_en && ds_hit)
      |=> ds_reg[DSPC_BOD_BIT] == $past(ds_cand[DSPC_BOD_BIT]))
    else $error("deep-sleep brown-out bit write lost");

  wake_fixed_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wake_reg & ~DSPC_WAKE_WMASK) == (DSPC_WAKE_RST & ~DSPC_WAKE_WMASK))
    else $error("wake-up reserved bits changed");

  rd_unmapped_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rif.rd_en && !rif.rd_ok)
      |=> rvalid && rresp == DSPC_RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read not answered with an error");
endmodule : dspc_top

// ==== verification/tb_top.sv ====
// Self-checking bench for the deep-sleep power configuration block
`timescale 1ns/10ps
module tb_top import dspc_pkg::*; ;
  logic clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, in_deep_sleep, prev_sleep;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic wdt_clock_lock, wdt_src_osc, wdt_src_rc, sleep_enter, sleep_exit;
  logic [15:0] analog_pd, ds_m, wk_m, pd_m;
  logic [31:0] r;
  int error_cnt = 0;
  int n_tests = 0;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [15:0] pq[$];
  localparam logic [31:0] UNMAPPED = 32'h4004_8238;

  dspc_top uut (.clk(clk), .reset_n(reset_n), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .wdt_clock_lock(wdt_clock_lock), .wdt_src_osc(wdt_src_osc),
    .wdt_src_rc(wdt_src_rc), .sleep_enter(sleep_enter),
    .sleep_exit(sleep_exit), .analog_pd(analog_pd),
    .in_deep_sleep(in_deep_sleep));

  always #25 clk = ~clk;

  task automatic mismatch(input string m);
    $display("mismatch at %0t: %s", $time, m);
    error_cnt++;
  endtask : mismatch

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic chk_read(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) mismatch("read data or response differs");
  endtask : chk_read

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) mismatch("write response differs");
  endtask : chk_resp

  task automatic chk_pd(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) mismatch("power-down controls differ");
  endtask : chk_pd

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    int n;
    bit aw_ok, w_ok;
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 0;
    w_ok = 0;
    n = 0;
    while (!(aw_ok && w_ok) && n < 50) begin
      @(posedge clk);
      n++;
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clk);
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (n >= 100) begin
      mismatch("write timed out");
      complete_run();
    end
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int n;
    rq.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    if (n >= 100) begin
      mismatch("read timed out");
      complete_run();
    end
    @(posedge clk);
  endtask : axi_rd

  // One pulse each; b2b puts the exit on the cycle right after the entry
  task automatic sleep_seq(input bit enter, input bit b2b);
    sleep_enter <= enter;
    sleep_exit <= !enter;
    @(posedge clk);
    sleep_enter <= 1'b0;
    sleep_exit <= b2b;
    @(posedge clk);
    sleep_exit <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : sleep_seq

  function automatic logic [15:0] wake_exp(input logic [15:0] o,
      input logic [15:0] n, input logic lk, input logic os, input logic rc);
    logic [15:0] e;
    e = n;
    if (lk && os) e[6] = o[6];
    if (lk && rc) e[1:0] = o[1:0];
    return (e & 16'h80FF) | 16'h0800;
  endfunction : wake_exp

  // Results are paired with notes in the order they were requested
  always @(posedge clk) begin
    if (reset_n === 1'b1) begin
      if (bvalid === 1'b1 && bready === 1'b1) begin
        if (bq.size() == 0) mismatch("unexpected write response");
        else chk_resp(bresp, bq.pop_front());
      end
      if (rvalid === 1'b1 && rready === 1'b1) begin
        if (rq.size() == 0) mismatch("unexpected read data");
        else chk_read({rresp, rdata}, rq.pop_front());
      end
      if (in_deep_sleep !== prev_sleep) begin
        if (pq.size() == 0) mismatch("unexpected sleep change");
        else chk_pd(analog_pd, pq.pop_front());
      end
    end
    prev_sleep = in_deep_sleep;
  end

  initial begin
    clk = 0;
    reset_n = 0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, wstrb} = '0;
    {wdt_clock_lock, wdt_src_osc, wdt_src_rc, sleep_enter, sleep_exit} = '0;
    r = $urandom(32'h5097fb8b);
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk_pd(analog_pd, 16'h80F0);
    axi_rd(DSPC_DS_ADDR, 32'h0000_FFFF, DSPC_RESP_OKAY);
    axi_rd(DSPC_WAKE_ADDR, 32'h0000_88F0, DSPC_RESP_OKAY);
    $display("test reset values done");
    axi_wr(UNMAPPED, 32'h0000_0000, 4'hF, DSPC_RESP_SLVERR);
    axi_rd(UNMAPPED, 32'h0000_0000, DSPC_RESP_SLVERR);
    // Lane 1 strobe off: upper byte keeps its reserved ones
    axi_wr(DSPC_DS_ADDR, 32'h0000_12B7, 4'h1, DSPC_RESP_OKAY);
    ds_m = 16'hFFB7;
    axi_rd(DSPC_DS_ADDR, {16'h0000, ds_m}, DSPC_RESP_OKAY);
    wk_m = 16'h88F0;
    $display("test unmapped and strobes done");
    for (int i = 0; i < 8; i++) begin
      wdt_clock_lock <= i[2];
      wdt_src_osc <= i[1];
      wdt_src_rc <= i[0];
      @(posedge clk);
      // Guarded bits and deep-sleep bits 0, 1 and 3 always try to flip; the rest are random
      r = $urandom;
      axi_wr(DSPC_DS_ADDR, {r[31:16], ~ds_m ^ (r[15:0] & 16'hFFB4)},
             4'hF, DSPC_RESP_OKAY);
      if (!(i[2] && i[1])) ds_m[6] = ~ds_m[6];
      ds_m = (ds_m & 16'h0040) | (~(ds_m | 16'h0040) ^ 16'hFFFF) & 16'h0000
             | ((~ds_m ^ (r[15:0] & 16'hFFB4)) & 16'hFFBF);
      axi_rd(DSPC_DS_ADDR, {16'h0000, ds_m}, DSPC_RESP_OKAY);
      r = $urandom;
      r[15:0] = ~wk_m ^ (r[15:0] & 16'hFFBC);
      wk_m = wake_exp(wk_m, r[15:0], i[2], i[1], i[0]);
      axi_wr(DSPC_WAKE_ADDR, r, 4'hF, DSPC_RESP_OKAY);
      axi_rd(DSPC_WAKE_ADDR, {16'h0000, wk_m}, DSPC_RESP_OKAY);
    end
    // Still locked: only a permitted value, wdt osc bit already clear
    ds_m = DSPC_DS_BOD_OFF;
    axi_wr(DSPC_DS_ADDR, {16'h0000, ds_m}, 4'hF, DSPC_RESP_OKAY);
    axi_rd(DSPC_DS_ADDR, {16'h0000, ds_m}, DSPC_RESP_OKAY);
    axi_rd(DSPC_STAT_ADDR, 32'h0000_003E, DSPC_RESP_OKAY);
    axi_wr(DSPC_STAT_ADDR, 32'h0000_0020, 4'hF, DSPC_RESP_OKAY);
    axi_rd(DSPC_STAT_ADDR, 32'h0000_001E, DSPC_RESP_OKAY);
    $display("test lock guard done");
    wdt_clock_lock <= 1'b0;
    wdt_src_osc <= 1'b0;
    wdt_src_rc <= 1'b0;
    @(posedge clk);
    for (int j = 0; j < 4; j++) begin
      ds_m = (j == 0) ? DSPC_DS_BOTH_ON : (j == 1) ? DSPC_DS_BOD_OFF :
             (j == 2) ? DSPC_DS_WDT_OFF : DSPC_DS_ALL_OFF;
      axi_wr(DSPC_DS_ADDR, {16'h0000, ds_m}, 4'hF, DSPC_RESP_OKAY);
      r = $urandom;
      wk_m = (r[15:0] & 16'h80FF) | 16'h0800;
      axi_wr(DSPC_WAKE_ADDR, r, 4'hF, DSPC_RESP_OKAY);
      pd_m = 16'h80B7 | (ds_m & 16'h0048);
      pq.push_back(pd_m);
      if (j == 3) pq.push_back(wk_m & 16'h80FF);
      // Oscillator frequency and bus clock gates lie outside this block
      sleep_seq(1'b1, j == 3);
      if (j < 3) begin
        sleep_seq(1'b1, 1'b0);
        chk_pd(analog_pd, pd_m);
        pq.push_back(wk_m & 16'h80FF);
        sleep_seq(1'b0, 1'b0);
      end
      sleep_seq(1'b0, 1'b0);
      chk_pd(analog_pd, wk_m & 16'h80FF);
    end
    $display("test sleep sequencing done");
    // Second reset with the wake-up register away from its reset value
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk_pd(analog_pd, 16'h80F0);
    axi_rd(DSPC_WAKE_ADDR, 32'h0000_88F0, DSPC_RESP_OKAY);
    axi_rd(DSPC_DS_ADDR, 32'h0000_FFFF, DSPC_RESP_OKAY);
    $display("test mid-run reset done");
    repeat (2) @(posedge clk);
    if (bq.size() + rq.size() + pq.size() != 0) mismatch("results missing");
    complete_run();
  end
endmodule : tb_top
